// [logic/adc_powerdown_config_regs.vh]
`ifndef ADC_POWERDOWN_CONFIG_REGS_VH
`define ADC_POWERDOWN_CONFIG_REGS_VH
// register offsets within the master page
`define ADDR_CORE_SLEEP_MASK_ONE 8'h20
`define ADDR_BUFFER_SLEEP_MASK_ONE 8'h21
`define ADDR_CORE_SLEEP_MASK_TWO 8'h23
`define ADDR_BUFFER_SLEEP_MASK_TWO 8'h24
`define ADDR_SLEEP_CONTROL 8'h26
`define ADDR_PERFORMANCE_SETTING_LOW 8'h39
`define ADDR_PERFORMANCE_SETTING_MID 8'h3A
`define ADDR_INPUT_COUPLING_CONTROL 8'h4F
`define ADDR_SYSREF_CONTROL 8'h53
`define ADDR_REGISTER_SLEEP_ENABLE 8'h55
`define ADDR_PERFORMANCE_SETTING_HIGH 8'h56
// field positions
`define BIT_WHOLE_CHIP_SLEEP 7
`define BIT_IGNORE_SLEEP_PIN 6
`define BIT_SLEEP_MASK_CHOICE 5
`define BIT_PERF_LOW_HI 7
`define BIT_PERF_LOW_LO 6
`define BIT_PERF_MID 6
`define BIT_PERF_HIGH 2
`define BIT_INPUT_DIRECT_COUPLING 0
`define BIT_SYSREF_IGNORE 6
`define BIT_SYSREF_HIGH_CM 1
`define BIT_REGISTER_SLEEP_ENABLE 4
// readable masks: write-only positions read as zero
`define RMASK_CORE_SLEEP 8'hFF
`define RMASK_BUFFER_SLEEP 8'hF0
`define RMASK_SLEEP_CONTROL 8'hE0
`define RMASK_PERF_LOW 8'hC0
`define RMASK_PERF_MID 8'h40
`define RMASK_INPUT_COUPLING 8'h01
`define RMASK_SYSREF 8'h42
`define RMASK_REGISTER_SLEEP 8'h10
`define RMASK_PERF_HIGH 8'h04
`define REG_RESET_VALUE 8'h00
`endif

// [logic/sleep_mask_reg.v]
`timescale 1ns/1ns
`include "adc_powerdown_config_regs.vh"
// one 8-bit configuration register; only bits in WMASK are stored
module sleep_mask_reg #(
  parameter [7:0] ADDR = 8'h00,
  parameter [7:0] WMASK = 8'hFF
) (
  input wire i_clk,
  input wire i_resetn,
  input wire i_wr_en,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_value
);
  // reserved positions never hold state, so stray writes cannot leak in
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_value <= `REG_RESET_VALUE;
    end else if (i_wr_en && (i_addr == ADDR)) begin
      o_value <= i_wdata & WMASK;
    end
  end
endmodule

// [logic/adc_powerdown_config_bank.v]
`timescale 1ns/1ns
`include "adc_powerdown_config_regs.vh"
module adc_powerdown_config_bank (
  input wire i_clk,
  input wire i_resetn,
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_sleep_pin,
  input wire i_sysref,
  output reg [7:0] o_rdata,
  output reg o_whole_chip_sleep,
  output reg [3:0] o_core_sleep_chan_a,
  output reg [3:0] o_core_sleep_chan_b,
  output reg [1:0] o_buffer_sleep_chan_a,
  output reg [1:0] o_buffer_sleep_chan_b,
  output reg [3:0] o_performance_setting,
  output reg o_input_direct_coupling_en,
  output reg o_sysref_high_common_mode_en,
  output reg o_sysref
);
  wire [7:0] core_one;
  wire [7:0] buf_one;
  wire [7:0] core_two;
  wire [7:0] buf_two;
  wire [7:0] perf_low;
  wire [7:0] perf_mid;
  wire [7:0] perf_high;
  wire [7:0] coupling;
  wire [7:0] sysref_ctl;
  wire [7:0] reg_sleep;
  reg [7:0] sleep_control_q;
  reg [2:0] pin_sync_q;
  reg [2:0] sysref_sync_q;
  reg pin_level_q;
  reg sysref_level_q;
  reg [7:0] rdata_d;
  reg [7:0] sel_core;
  reg [7:0] sel_buf;
  reg pin_sleep;
  reg reg_sleep_on;

  // mask one registers
  sleep_mask_reg #(.ADDR(`ADDR_CORE_SLEEP_MASK_ONE), .WMASK(`RMASK_CORE_SLEEP)) u_core_one (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_wr_en(i_wr_en),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .o_value(core_one)
  );
  sleep_mask_reg #(.ADDR(`ADDR_BUFFER_SLEEP_MASK_ONE), .WMASK(`RMASK_BUFFER_SLEEP)) u_buf_one (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_wr_en(i_wr_en),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .o_value(buf_one)
  );
  // mask two registers
  sleep_mask_reg #(.ADDR(`ADDR_CORE_SLEEP_MASK_TWO), .WMASK(`RMASK_CORE_SLEEP)) u_core_two (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_wr_en(i_wr_en),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .o_value(core_two)
  );
  sleep_mask_reg #(.ADDR(`ADDR_BUFFER_SLEEP_MASK_TWO), .WMASK(`RMASK_BUFFER_SLEEP)) u_buf_two (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_wr_en(i_wr_en),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .o_value(buf_two)
  );
  // performance setting pieces; write-only bit 3 still stored for use
  sleep_mask_reg #(.ADDR(`ADDR_PERFORMANCE_SETTING_LOW), .WMASK(`RMASK_PERF_LOW)) u_perf_low (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_wr_en(i_wr_en),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .o_value(perf_low)
  );
  sleep_mask_reg #(.ADDR(`ADDR_PERFORMANCE_SETTING_MID), .WMASK(`RMASK_PERF_MID)) u_perf_mid (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_wr_en(i_wr_en),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .o_value(perf_mid)
  );
  sleep_mask_reg #(.ADDR(`ADDR_PERFORMANCE_SETTING_HIGH), .WMASK(`RMASK_PERF_HIGH)) u_perf_high (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_wr_en(i_wr_en),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .o_value(perf_high)
  );
  // input coupling control
  sleep_mask_reg #(.ADDR(`ADDR_INPUT_COUPLING_CONTROL), .WMASK(`RMASK_INPUT_COUPLING)) u_coup (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_wr_en(i_wr_en),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .o_value(coupling)
  );
  // sysref ignore and common-mode options
  sleep_mask_reg #(.ADDR(`ADDR_SYSREF_CONTROL), .WMASK(`RMASK_SYSREF)) u_sysref (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_wr_en(i_wr_en),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .o_value(sysref_ctl)
  );
  // register sleep enable; gates whichever mask is selected
  sleep_mask_reg #(.ADDR(`ADDR_REGISTER_SLEEP_ENABLE), .WMASK(`RMASK_REGISTER_SLEEP)) u_rsleep (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_wr_en(i_wr_en),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .o_value(reg_sleep)
  );

  // sleep control: chip sleep bit only lands when override was set before this access;
  // setting both in one write leaves it unchanged, so a stray write cannot sleep the part
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sleep_control_q <= `REG_RESET_VALUE;
    end else if (i_wr_en && (i_addr == `ADDR_SLEEP_CONTROL)) begin
      sleep_control_q[`BIT_IGNORE_SLEEP_PIN] <= i_wdata[`BIT_IGNORE_SLEEP_PIN];
      sleep_control_q[`BIT_SLEEP_MASK_CHOICE] <= i_wdata[`BIT_SLEEP_MASK_CHOICE];
      if (sleep_control_q[`BIT_IGNORE_SLEEP_PIN]) begin
        sleep_control_q[`BIT_WHOLE_CHIP_SLEEP] <= i_wdata[`BIT_WHOLE_CHIP_SLEEP];
      end
    end
  end

  // pin inputs pass three flops; level accepted once stages two and three agree
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_sync_q <= 3'h0;
      sysref_sync_q <= 3'h0;
      pin_level_q <= 1'h0;
      sysref_level_q <= 1'h0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], i_sleep_pin};
      sysref_sync_q <= {sysref_sync_q[1:0], i_sysref};
      if (pin_sync_q[1] == pin_sync_q[2]) begin
        pin_level_q <= pin_sync_q[2];
      end
      if (sysref_sync_q[1] == sysref_sync_q[2]) begin
        sysref_level_q <= sysref_sync_q[2];
      end
    end
  end

  // mask selection and sleep sources
  always @* begin
    if (sleep_control_q[`BIT_SLEEP_MASK_CHOICE]) begin
      sel_core = core_two;
      sel_buf = buf_two;
    end else begin
      sel_core = core_one;
      sel_buf = buf_one;
    end
    pin_sleep = pin_level_q & ~sleep_control_q[`BIT_IGNORE_SLEEP_PIN];
    reg_sleep_on = reg_sleep[`BIT_REGISTER_SLEEP_ENABLE];
  end

  // read mux; write-only positions read zero
  always @* begin
    case (i_addr)
      `ADDR_CORE_SLEEP_MASK_ONE: rdata_d = core_one;
      `ADDR_BUFFER_SLEEP_MASK_ONE: rdata_d = buf_one;
      `ADDR_CORE_SLEEP_MASK_TWO: rdata_d = core_two;
      `ADDR_BUFFER_SLEEP_MASK_TWO: rdata_d = buf_two;
      `ADDR_SLEEP_CONTROL: rdata_d = sleep_control_q & `RMASK_SLEEP_CONTROL;
      `ADDR_PERFORMANCE_SETTING_LOW: rdata_d = perf_low;
      `ADDR_PERFORMANCE_SETTING_MID: rdata_d = perf_mid;
      `ADDR_INPUT_COUPLING_CONTROL: rdata_d = coupling;
      `ADDR_SYSREF_CONTROL: rdata_d = sysref_ctl;
      `ADDR_REGISTER_SLEEP_ENABLE: rdata_d = reg_sleep;
      default: rdata_d = `REG_RESET_VALUE;
    endcase
  end

  // registered outputs; pin sleep or whole-chip sleep raises o_whole_chip_sleep only, the mask outputs are not forced
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= `REG_RESET_VALUE;
      o_whole_chip_sleep <= 1'h0;
      o_core_sleep_chan_a <= 4'h0;
      o_core_sleep_chan_b <= 4'h0;
      o_buffer_sleep_chan_a <= 2'h0;
      o_buffer_sleep_chan_b <= 2'h0;
      o_performance_setting <= 4'h0;
      o_input_direct_coupling_en <= 1'h0;
      o_sysref_high_common_mode_en <= 1'h0;
      o_sysref <= 1'h0;
    end else begin
      if (i_rd_en) begin
        o_rdata <= rdata_d;
      end
      o_whole_chip_sleep <= sleep_control_q[`BIT_WHOLE_CHIP_SLEEP] | pin_sleep;
      o_core_sleep_chan_a <= reg_sleep_on ? sel_core[7:4] : 4'h0;
      o_core_sleep_chan_b <= reg_sleep_on ? sel_core[3:0] : 4'h0;
      o_buffer_sleep_chan_b <= reg_sleep_on ? sel_buf[7:6] : 2'h0;
      o_buffer_sleep_chan_a <= reg_sleep_on ? sel_buf[5:4] : 2'h0;
      o_performance_setting <= {perf_high[`BIT_PERF_HIGH], perf_mid[`BIT_PERF_MID],
                                perf_low[`BIT_PERF_LOW_HI], perf_low[`BIT_PERF_LOW_LO]};
      o_input_direct_coupling_en <= coupling[`BIT_INPUT_DIRECT_COUPLING];
      o_sysref_high_common_mode_en <= sysref_ctl[`BIT_SYSREF_HIGH_CM];
      o_sysref <= sysref_level_q & ~sysref_ctl[`BIT_SYSREF_IGNORE];
    end
  end
endmodule

// [verification/adc_powerdown_config_bank_assertions.sv]
`timescale 1ns/1ns
module adc_powerdown_config_bank_checker (
  input wire i_clk, input wire i_resetn, input wire i_wr_en, input wire i_rd_en,
  input wire [7:0] i_addr, input wire [7:0] i_wdata, input wire i_sleep_pin,
  input wire [7:0] o_rdata, input wire o_whole_chip_sleep, input wire o_sysref,
  input wire o_input_direct_coupling_en, input wire o_sysref_high_common_mode_en
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // shadow of sleep control bits 7:6; bit 7 only changes if override was already set
  logic [1:0] ctrl_q;
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) ctrl_q <= 2'h0;
    else if (i_wr_en && i_addr == 8'h26) begin
      ctrl_q <= {ctrl_q[0] ? i_wdata[7] : ctrl_q[1], i_wdata[6]};
    end
  end
  sequence quiet_pin_s; !i_sleep_pin [*6]; endsequence
  // register stage then output stage: the new bit shows two edges after the write
  property follow_p(logic [7:0] a, logic d, logic o);
    (i_wr_en && i_addr == a) |-> ##2 (o == $past(d, 2));
  endproperty
  reset_clear_a: assert property (
    $rose(i_resetn) |-> o_rdata == 8'h00 && !o_whole_chip_sleep)
    else $error("outputs not clear after reset");
  coupling_follow_a: assert property (
    follow_p(8'h4F, i_wdata[0], o_input_direct_coupling_en))
    else $error("coupling output does not follow its bit");
  sysref_cm_a: assert property (
    follow_p(8'h53, i_wdata[1], o_sysref_high_common_mode_en))
    else $error("sysref common mode output does not follow its bit");
  global_refused_a: assert property (quiet_pin_s ##0
    (i_wr_en && i_addr == 8'h26 && ctrl_q == 2'h0) |-> ##3 !o_whole_chip_sleep)
    else $error("sleep taken without override");
  global_taken_a: assert property (i_wr_en && i_addr == 8'h26 && ctrl_q[0] && i_wdata[7]
    |-> ##[1:3] o_whole_chip_sleep) else $error("whole chip sleep not raised");
  pin_ignored_a: assert property ((ctrl_q == 2'h1) [*4] |-> !o_whole_chip_sleep)
    else $error("sleep pin not ignored");
  pin_follow_a: assert property (
    (ctrl_q == 2'h0 && i_sleep_pin) [*8] |-> o_whole_chip_sleep)
    else $error("sleep pin has no effect");
  unmapped_read_a: assert property (i_rd_en && i_addr == 8'h25 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  sysref_ignore_a: assert property (i_wr_en && i_addr == 8'h53 && i_wdata[6]
    |-> ##3 !o_sysref [*4]) else $error("sysref passed while ignored");
endmodule
bind adc_powerdown_config_bank adc_powerdown_config_bank_checker u_chk (.*);

// [verification/adc_powerdown_config_bank_test.sv]
`timescale 1ns/1ns
module adc_powerdown_config_bank_test;
  logic i_clk = 0, i_resetn = 0, i_wr_en = 0, i_rd_en = 0, i_sleep_pin = 0, i_sysref = 0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
  logic o_whole_chip_sleep, o_input_direct_coupling_en, o_sysref_high_common_mode_en, o_sysref;
  logic [3:0] o_core_sleep_chan_a, o_core_sleep_chan_b, o_performance_setting;
  logic [1:0] o_buffer_sleep_chan_a, o_buffer_sleep_chan_b;
  int fail_count = 0;
  int n_tests = 0;
  // address, write data, expected readback; reserved bits of mapped registers are written as zero
  logic [23:0] rows [0:11] = '{24'h20FFFF, 24'h215050, 24'h23A5A5, 24'h248080, 24'h26C040,
    24'h39C0C0, 24'h3A4040, 24'h4F0101, 24'h534242, 24'h551010, 24'h560400, 24'h255A00};
  always #5 i_clk = ~i_clk;
  adc_powerdown_config_bank u_adc_powerdown_config_bank (.*);
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // strobes change at the falling edge and are dropped one cycle later
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk); i_wr_en = 1; i_addr = a; i_wdata = d;
    @(negedge i_clk); i_wr_en = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge i_clk); i_rd_en = 1; i_addr = a;
    @(negedge i_clk); i_rd_en = 0;
    @(negedge i_clk); chk(o_rdata, e);
  endtask
  task reset_dut;
    i_resetn = 0;
    repeat (6) @(negedge i_clk);
    i_resetn = 1;
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    reset_dut;
    chk({o_performance_setting, o_core_sleep_chan_a}, 8'h00);
    i_sysref = 1;
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    repeat (3) @(negedge i_clk);
    chk({o_performance_setting, o_core_sleep_chan_a}, 8'hFF);
    chk({o_core_sleep_chan_b, o_buffer_sleep_chan_a, o_buffer_sleep_chan_b}, 8'hF5);
    chk({6'h00, o_input_direct_coupling_en, o_sysref_high_common_mode_en}, 8'h03);
    chk({7'h00, o_sysref}, 8'h00);
    // override already set, so the sleep bit is now accepted; mask two selected
    wr(8'h26, 8'hE0);
    repeat (3) @(negedge i_clk);
    chk({o_core_sleep_chan_a, o_core_sleep_chan_b}, 8'hA5);
    chk({o_whole_chip_sleep, 3'h0, o_buffer_sleep_chan_a, o_buffer_sleep_chan_b}, 8'h82);
    wr(8'h55, 8'h00);
    wr(8'h53, 8'h00);
    repeat (3) @(negedge i_clk);
    chk({o_core_sleep_chan_a, o_core_sleep_chan_b}, 8'h00);
    chk({4'h0, o_buffer_sleep_chan_a, o_buffer_sleep_chan_b}, 8'h00);
    chk({6'h00, o_sysref, o_sysref_high_common_mode_en}, 8'h02);
    // override was set, so bit 7 clears; pin still low, so sleep must drop
    wr(8'h26, 8'h20);
    repeat (2) @(negedge i_clk);
    chk({7'h00, o_whole_chip_sleep}, 8'h00);
    // pin path crosses a synchroniser, so wait a bounded number of cycles
    i_sleep_pin = 1;
    for (int k = 0; k < 10 && o_whole_chip_sleep !== 1'b1; k++) @(negedge i_clk);
    chk({7'h00, o_whole_chip_sleep}, 8'h01);
    wr(8'h26, 8'h60);
    repeat (8) @(negedge i_clk);
    chk({7'h00, o_whole_chip_sleep}, 8'h00);
    i_sleep_pin = 0;
    reset_dut;
    chk({6'h00, o_input_direct_coupling_en, o_sysref_high_common_mode_en}, 8'h00);
    chk({6'h00, o_whole_chip_sleep, o_sysref}, 8'h00);
    chk({4'h0, o_buffer_sleep_chan_a, o_buffer_sleep_chan_b}, 8'h00);
    foreach (rows[i]) rd(rows[i][23:16], 8'h00);
    chk({o_performance_setting, o_core_sleep_chan_b}, 8'h00);
    give_verdict;
  end
endmodule
